// ---- lsip_pkg.sv ----
`default_nettype none
package lsip_pkg;

	// APB data and byte address widths
	localparam int DATA_W = 32;
	localparam int PORT_W = 8;
	localparam int IDX_W  = 9;
	localparam int ADDR_W = IDX_W + 2;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_BIDIR_DATA  = 9'h008;
	localparam logic [IDX_W-1:0] IDX_ONE_DATA    = 9'h009;
	localparam logic [IDX_W-1:0] IDX_BIDIR_DIR   = 9'h088;
	localparam logic [IDX_W-1:0] IDX_ONE_DIR     = 9'h089;
	localparam logic [IDX_W-1:0] IDX_TWO_DATA    = 9'h107;
	localparam logic [IDX_W-1:0] IDX_THREE_DATA  = 9'h108;
	localparam logic [IDX_W-1:0] IDX_SEG_ENABLE  = 9'h10D;
	localparam logic [IDX_W-1:0] IDX_TWO_DIR     = 9'h187;
	localparam logic [IDX_W-1:0] IDX_THREE_DIR   = 9'h188;

	// Reset values
	localparam logic [PORT_W-1:0] RST_DATA       = 8'h00;
	localparam logic [PORT_W-1:0] RST_DIR        = 8'hFF;
	localparam logic [PORT_W-1:0] RST_SEG_ENABLE = 8'hFF;

	// Segment-enable field positions
	localparam int SEG_G0_BIT  = 0;
	localparam int SEG_G5_BIT  = 1;
	localparam int SEG_G9_BIT  = 2;
	localparam int SEG_G12_BIT = 3;
	localparam int SEG_G16_BIT = 4;
	localparam int SEG_G20_BIT = 5;
	localparam int SEG_G27_BIT = 6;
	localparam int SEG_G29_BIT = 7;

	// Pins of the shared bidirectional port that may drive as outputs
	localparam logic [PORT_W-1:0] BIDIR_GPIO_MASK = 8'h1F;
	localparam logic [PORT_W-1:0] NO_GPIO_MASK    = 8'h00;
	localparam logic [PORT_W-1:0] ALL_PINS_MASK   = 8'hFF;

	// APB slave phase, Gray coded
	typedef enum logic [1:0] {
		LSIP_IDLE   = 2'b00,
		LSIP_ACCESS = 2'b01
	} lsip_apb_state_t;

endpackage
`default_nettype wire

// ---- lsip_port_slice.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsip_port_slice #(
	parameter logic [7:0] CAN_OUT = 8'h00,
	parameter logic [7:0] PRESENT = 8'hFF
) (
	input  wire logic [7:0] lcdOwn,
	input  wire logic [7:0] dir,
	input  wire logic [7:0] latch,
	input  wire logic [7:0] lcdVal,
	input  wire logic [7:0] pinIn,
	output logic      [7:0] drvVal,
	output logic      [7:0] drvOe,
	output logic      [7:0] readVal
);
	import lsip_pkg::*;

	logic [7:0] lcdPins;
	logic [7:0] digOut;

	// LCD ownership wins over direction bits
	assign lcdPins = lcdOwn & PRESENT; // RL5
	// Only output-capable digital pins with direction zero drive
	assign digOut  = ~lcdOwn & ~dir & CAN_OUT & PRESENT; // RL21 RL26 RL3

	// Pin driver: segment value in LCD mode, latch in output mode
	assign drvOe   = lcdPins | digOut;
	assign drvVal  = (lcdPins & lcdVal) | (digOut & latch);

	// Read gives pin levels of digital pins; LCD pins read zero
	assign readVal = pinIn & ~lcdOwn & PRESENT; // RL22
endmodule
`default_nettype wire

// ---- lsip_top.sv ----
// Functional notes
// [RL1] Bidirectional shared port is 8 bits; low five pins GPIO or segment
// [RL2] Its upper three pins: digital input, segment or common, never output
// [RL3] Its direction bits steer only the low five pins in digital mode
// [RL4] After reset every shared pin belongs to the LCD driver
// [RL5] A set segment-enable bit keeps pins with LCD, direction ignored
// [RL6] Software clears segment-enable bits to use a group digitally
// [RL7] The other three ports are inputs, each pin shared with a segment
// [RL8] Segment-enable is 8 bits, groups 29..0 high to low, resets ones
// [RL9] Clearing group 0 gives the low five bidirectional pins to GPIO
// [RL10] Clearing group 29 makes the upper three bidirectional pins inputs
// [RL11] Groups 27, 5, 9 cleared: port one and port three top pin digital
// [RL12] Groups 16 and 12 cleared: all of port two digital
// [RL13] Groups 27 and 20 cleared: port three and port one top pin digital
// [RL14] Any reset: data latches zero, direction registers all ones
// [RL15] Bidirectional pins 0..4 carry segments 0..4 in LCD mode
// [RL16] Pins 5..7 carry seg29/lcd_common_three, seg30/lcd_common_two, seg31/lcd_common_one
// [RL17] Port one pins 0..6 carry segments 5..11, pin 7 segment 27
// [RL18] Port two pins 0..7 carry segments 12..19
// [RL19] Port three pins 0..6 carry segments 20..26, pin 7 segment 28
// [RL20] Top pins of ports one and three absent on the small package
// [RL21] Direction one is high-impedance input, zero drives the latch
// [RL22] Data read returns pin levels, data write stores the latch
// [RL23] Write lands at cycle end, read samples pins at cycle start
// [RL24] Group 5 owns port one pins 0..3, group 9 pins 4..6
// [RL25] Group 27 owns both top pins, group 20 port three pins 0..6
// [RL26] Direction bits of input-only pins never make them drive
`timescale 1ns/1ps
`default_nettype none
module lsip_top #(
	parameter logic WIDE_PKG = 1'b1
) (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          ce,
	input  wire logic [lsip_pkg::ADDR_W-1:0]   paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [lsip_pkg::DATA_W-1:0]   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [lsip_pkg::DATA_W-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [31:0]                   segDrive,
	input  wire logic [3:1]                    comDrive,
	input  wire logic                          comMode,
	input  wire logic [lsip_pkg::PORT_W-1:0]   bidirPinIn,
	output logic      [lsip_pkg::PORT_W-1:0]   bidirPinOut,
	output logic      [lsip_pkg::PORT_W-1:0]   bidirPinOe,
	input  wire logic [lsip_pkg::PORT_W-1:0]   onePinIn,
	output logic      [lsip_pkg::PORT_W-1:0]   onePinOut,
	output logic      [lsip_pkg::PORT_W-1:0]   onePinOe,
	input  wire logic [lsip_pkg::PORT_W-1:0]   twoPinIn,
	output logic      [lsip_pkg::PORT_W-1:0]   twoPinOut,
	output logic      [lsip_pkg::PORT_W-1:0]   twoPinOe,
	input  wire logic [lsip_pkg::PORT_W-1:0]   threePinIn,
	output logic      [lsip_pkg::PORT_W-1:0]   threePinOut,
	output logic      [lsip_pkg::PORT_W-1:0]   threePinOe,
	output logic      [lsip_pkg::PORT_W-1:0]   segPinEnable
);
	import lsip_pkg::*;

	// Whole state of the block
	typedef struct packed {
		lsip_apb_state_t   st;
		logic [PORT_W-1:0] bidirData;
		logic [PORT_W-1:0] bidirDir;
		logic [PORT_W-1:0] oneDir;
		logic [PORT_W-1:0] twoDir;
		logic [PORT_W-1:0] threeDir;
		logic [PORT_W-1:0] segEn;
		logic [DATA_W-1:0] rdata;
		logic              ready;
		logic              err;
		logic [PORT_W-1:0] bidirOut;
		logic [PORT_W-1:0] bidirOe;
		logic [PORT_W-1:0] oneOut;
		logic [PORT_W-1:0] oneOe;
		logic [PORT_W-1:0] twoOut;
		logic [PORT_W-1:0] twoOe;
		logic [PORT_W-1:0] threeOut;
		logic [PORT_W-1:0] threeOe;
	} lsip_state_t;

	localparam logic [PORT_W-1:0] SMALL_PKG_MASK =
		{WIDE_PKG, 7'h7F};

	lsip_state_t q;
	lsip_state_t d;

	logic [IDX_W-1:0]  idx;
	logic              aligned;
	logic              mapped;
	logic [PORT_W-1:0] readSel;
	logic              setup;
	logic              commit;

	// Ownership of each pin by the LCD driver, per segment group
	logic [PORT_W-1:0] bidirOwn;
	logic [PORT_W-1:0] oneOwn;
	logic [PORT_W-1:0] twoOwn;
	logic [PORT_W-1:0] threeOwn;

	// Segment or common value routed to each pin
	logic [PORT_W-1:0] bidirLcd;
	logic [PORT_W-1:0] oneLcd;
	logic [PORT_W-1:0] twoLcd;
	logic [PORT_W-1:0] threeLcd;

	// Pin drive and read values from the slices
	logic [PORT_W-1:0] bidirVal;
	logic [PORT_W-1:0] bidirEn;
	logic [PORT_W-1:0] bidirRd;
	logic [PORT_W-1:0] oneVal;
	logic [PORT_W-1:0] oneEn;
	logic [PORT_W-1:0] oneRd;
	logic [PORT_W-1:0] twoVal;
	logic [PORT_W-1:0] twoEn;
	logic [PORT_W-1:0] twoRd;
	logic [PORT_W-1:0] threeVal;
	logic [PORT_W-1:0] threeEn;
	logic [PORT_W-1:0] threeRd;

	// Group-to-pin mapping of the segment-enable bits
	assign bidirOwn = {{3{q.segEn[SEG_G29_BIT]}},
		{5{q.segEn[SEG_G0_BIT]}}}; // RL9 RL10
	assign oneOwn   = {q.segEn[SEG_G27_BIT],
		{3{q.segEn[SEG_G9_BIT]}},
		{4{q.segEn[SEG_G5_BIT]}}}; // RL11 RL24
	assign twoOwn   = {{4{q.segEn[SEG_G16_BIT]}},
		{4{q.segEn[SEG_G12_BIT]}}}; // RL12
	assign threeOwn = {q.segEn[SEG_G27_BIT],
		{7{q.segEn[SEG_G20_BIT]}}}; // RL13 RL25

	// Segment routing; upper bidirectional pins may carry commons
	assign bidirLcd = comMode ?
		{comDrive[1], comDrive[2], comDrive[3], segDrive[4:0]} :
		{segDrive[31:29], segDrive[4:0]}; // RL15 RL16
	assign oneLcd   = {segDrive[27], segDrive[11:5]}; // RL17
	assign twoLcd   = segDrive[19:12]; // RL18
	assign threeLcd = {segDrive[28], segDrive[26:20]}; // RL19

	// Bidirectional port: only the low five pins can be outputs
	lsip_port_slice #(
		.CAN_OUT (BIDIR_GPIO_MASK),
		.PRESENT (ALL_PINS_MASK)
	) u_bidir (
		.lcdOwn  (bidirOwn),
		.dir     (q.bidirDir),
		.latch   (q.bidirData),
		.lcdVal  (bidirLcd),
		.pinIn   (bidirPinIn),
		.drvVal  (bidirVal),
		.drvOe   (bidirEn),
		.readVal (bidirRd)
	); // RL1 RL2

	// Port one: input only, top pin absent on the small package
	lsip_port_slice #(
		.CAN_OUT (NO_GPIO_MASK),
		.PRESENT (SMALL_PKG_MASK)
	) u_one (
		.lcdOwn  (oneOwn),
		.dir     (q.oneDir),
		.latch   (RST_DATA),
		.lcdVal  (oneLcd),
		.pinIn   (onePinIn),
		.drvVal  (oneVal),
		.drvOe   (oneEn),
		.readVal (oneRd)
	); // RL7 RL20

	// Port two: input only
	lsip_port_slice #(
		.CAN_OUT (NO_GPIO_MASK),
		.PRESENT (ALL_PINS_MASK)
	) u_two (
		.lcdOwn  (twoOwn),
		.dir     (q.twoDir),
		.latch   (RST_DATA),
		.lcdVal  (twoLcd),
		.pinIn   (twoPinIn),
		.drvVal  (twoVal),
		.drvOe   (twoEn),
		.readVal (twoRd)
	); // RL7

	// Port three: input only, top pin absent on the small package
	lsip_port_slice #(
		.CAN_OUT (NO_GPIO_MASK),
		.PRESENT (SMALL_PKG_MASK)
	) u_three (
		.lcdOwn  (threeOwn),
		.dir     (q.threeDir),
		.latch   (RST_DATA),
		.lcdVal  (threeLcd),
		.pinIn   (threePinIn),
		.drvVal  (threeVal),
		.drvOe   (threeEn),
		.readVal (threeRd)
	); // RL7 RL20

	// Address decode on word index
	assign idx     = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign setup   = psel && !penable && (q.st == LSIP_IDLE);
	assign commit  = psel && penable && pwrite && q.ready &&
		!q.err && pstrb[0];

	// Read multiplexer; unmapped indices flag an error
	always_comb begin
		readSel = '0;
		mapped  = 1'b1;
		case (idx)
			IDX_BIDIR_DATA: begin
				readSel = bidirRd; // RL22
			end
			IDX_ONE_DATA: begin
				readSel = oneRd;
			end
			IDX_TWO_DATA: begin
				readSel = twoRd;
			end
			IDX_THREE_DATA: begin
				readSel = threeRd;
			end
			IDX_BIDIR_DIR: begin
				readSel = q.bidirDir;
			end
			IDX_ONE_DIR: begin
				readSel = q.oneDir;
			end
			IDX_TWO_DIR: begin
				readSel = q.twoDir;
			end
			IDX_THREE_DIR: begin
				readSel = q.threeDir;
			end
			IDX_SEG_ENABLE: begin
				readSel = q.segEn;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Next state: APB phase, register writes and pin drivers
	always_comb begin
		d = q;
		d.ready = 1'b0;
		case (q.st)
			LSIP_IDLE: begin
				if (setup) begin
					// Pins are sampled in the setup cycle
					d.st    = LSIP_ACCESS;
					d.ready = 1'b1;
					d.err   = !(mapped && aligned);
					d.rdata = (mapped && aligned) ?
						{{(DATA_W-PORT_W){1'b0}}, readSel} :
						'0; // RL23
				end
			end
			LSIP_ACCESS: begin
				d.st    = LSIP_IDLE;
				d.err   = 1'b0;
				d.rdata = '0;
			end
			default: begin
				d.st = LSIP_IDLE;
			end
		endcase

		// Writes land at the completing edge of the access
		if (commit) begin
			case (idx)
				IDX_BIDIR_DATA: begin
					d.bidirData = pwdata[PORT_W-1:0]; // RL22 RL23
				end
				IDX_BIDIR_DIR: begin
					d.bidirDir = pwdata[PORT_W-1:0];
				end
				IDX_ONE_DIR: begin
					d.oneDir = pwdata[PORT_W-1:0];
				end
				IDX_TWO_DIR: begin
					d.twoDir = pwdata[PORT_W-1:0];
				end
				IDX_THREE_DIR: begin
					d.threeDir = pwdata[PORT_W-1:0];
				end
				IDX_SEG_ENABLE: begin
					d.segEn = pwdata[PORT_W-1:0]; // RL6 RL8
				end
				default: begin
					d.segEn = q.segEn;
				end
			endcase
		end

		// Registered pin drivers
		d.bidirOut = bidirVal;
		d.bidirOe  = bidirEn; // RL3 RL21
		d.oneOut   = oneVal;
		d.oneOe    = oneEn; // RL26
		d.twoOut   = twoVal;
		d.twoOe    = twoEn; // RL26
		d.threeOut = threeVal;
		d.threeOe  = threeEn; // RL26
	end

	// State register; reset hands every shared pin to the LCD driver
	always_ff @(posedge clk) begin
		if (!resetn) begin
			q.st        <= LSIP_IDLE;
			q.bidirData <= RST_DATA; // RL14
			q.bidirDir  <= RST_DIR; // RL14
			q.oneDir    <= RST_DIR;
			q.twoDir    <= RST_DIR;
			q.threeDir  <= RST_DIR;
			q.segEn     <= RST_SEG_ENABLE; // RL4 RL8
			q.rdata     <= '0;
			q.ready     <= 1'b0;
			q.err       <= 1'b0;
			q.bidirOut  <= RST_DATA;
			q.bidirOe   <= RST_DATA;
			q.oneOut    <= RST_DATA;
			q.oneOe     <= RST_DATA;
			q.twoOut    <= RST_DATA;
			q.twoOe     <= RST_DATA;
			q.threeOut  <= RST_DATA;
			q.threeOe   <= RST_DATA;
		end else if (ce) begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign prdata       = q.rdata;
	assign pready       = q.ready;
	assign pslverr      = q.err; // Error is only ever set with ready
	assign bidirPinOut  = q.bidirOut;
	assign bidirPinOe   = q.bidirOe;
	assign onePinOut    = q.oneOut;
	assign onePinOe     = q.oneOe;
	assign twoPinOut    = q.twoOut;
	assign twoPinOe     = q.twoOe;
	assign threePinOut  = q.threeOut;
	assign threePinOe   = q.threeOe;
	assign segPinEnable = q.segEn;
endmodule
`default_nettype wire

// ---- lsip_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsip_pin_model (
	input  wire logic [31:0] ext,
	input  wire logic [7:0]  bidirPinOut,
	input  wire logic [7:0]  bidirPinOe,
	input  wire logic [7:0]  onePinOut,
	input  wire logic [7:0]  onePinOe,
	input  wire logic [7:0]  twoPinOut,
	input  wire logic [7:0]  twoPinOe,
	input  wire logic [7:0]  threePinOut,
	input  wire logic [7:0]  threePinOe,
	output logic      [7:0]  bidirPinIn,
	output logic      [7:0]  onePinIn,
	output logic      [7:0]  twoPinIn,
	output logic      [7:0]  threePinIn
);
	// Pin level: block drives where enabled, outside world elsewhere
	assign bidirPinIn = (bidirPinOut & bidirPinOe) | (ext[7:0] & ~bidirPinOe);
	assign onePinIn   = (onePinOut & onePinOe) | (ext[15:8] & ~onePinOe);
	assign twoPinIn   = (twoPinOut & twoPinOe) | (ext[23:16] & ~twoPinOe);
	assign threePinIn = (threePinOut & threePinOe) |
		(ext[31:24] & ~threePinOe);
endmodule
`default_nettype wire

// ---- lsip_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsip_top_chk #(
	parameter logic WIDE_PKG = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        ce,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	input  wire logic [31:0] segDrive,
	input  wire logic [3:1]  comDrive,
	input  wire logic        comMode,
	input  wire logic [7:0]  bidirPinOut,
	input  wire logic [7:0]  bidirPinOe,
	input  wire logic [7:0]  onePinOe,
	input  wire logic [7:0]  twoPinOut,
	input  wire logic [7:0]  twoPinOe,
	input  wire logic [7:0]  threePinOe,
	input  wire logic [7:0]  segPinEnable
);
	logic [2:0] upperExp;
	// Expected LCD value on the upper three shared pins
	assign upperExp = comMode ? {comDrive[1], comDrive[2], comDrive[3]}
		: segDrive[31:29];
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_ready_pulse: assert property (pready && ce |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_setup: assert property (psel && !penable && !pready &&
		ce |=> pready) else $error("no answer after setup");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == '0)
		else $error("prdata not zero outside answer");
	// Pin registers only follow the enables on cycles with ce high
	a_lcd_low: assert property ($past(resetn) && $past(ce) &&
		$past(segPinEnable[0]) |-> bidirPinOe[4:0] == 5'h1F &&
		bidirPinOut[4:0] == $past(segDrive[4:0]))
		else $error("low pins left the LCD");
	a_upper_in: assert property ($past(resetn) && $past(ce) &&
		!$past(segPinEnable[7]) |-> bidirPinOe[7:5] == 3'h0)
		else $error("upper pins driven");
	a_upper_lcd: assert property ($past(resetn) && $past(ce) &&
		$past(segPinEnable[7]) |-> bidirPinOut[7:5] == $past(upperExp))
		else $error("upper LCD value");
	a_input_only: assert property ($past(ce) &&
		onePinOe[3:0] != 4'h0 |-> $past(segPinEnable[1]))
		else $error("input pin driven");
	a_two_lcd: assert property ($past(resetn) && $past(ce) &&
		$past(segPinEnable[3]) |-> twoPinOe[3:0] == 4'hF &&
		twoPinOut[3:0] == $past(segDrive[15:12]))
		else $error("port two LCD value");
	a_top_pins: assert property ($past(resetn) && $past(ce) &&
		$past(segPinEnable[6]) |-> onePinOe[7] == WIDE_PKG &&
		threePinOe[7] == WIDE_PKG) else $error("top pins wrong");
	a_seg_reset: assert property (!$past(resetn) |-> segPinEnable == 8'hFF)
		else $error("segment enable reset");
endmodule
bind lsip_top lsip_top_chk #(.WIDE_PKG(WIDE_PKG)) u_lsip_top_chk (
	.clk, .resetn, .psel, .penable, .ce, .pready, .pslverr, .prdata,
	.segDrive, .comDrive, .comMode, .bidirPinOut, .bidirPinOe, .onePinOe,
	.twoPinOut, .twoPinOe, .threePinOe, .segPinEnable
);
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lsip_pkg::*;
	typedef struct packed {
		logic w;
		logic [IDX_W-1:0] i;
		logic [7:0] d;
		logic [7:0] x;
		logic e;
	} lsip_row_t;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, comMode, e;
	logic ce;
	logic [3:0] pstrb;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, segDrive, ext, r;
	logic [3:1] comDrive;
	logic [7:0] bidirPinIn, bidirPinOut, bidirPinOe, onePinIn, onePinOut;
	logic [7:0] onePinOe, twoPinIn, twoPinOut, twoPinOe, threePinIn;
	logic [7:0] threePinOut, threePinOe, segPinEnable;
	int fails, compares, cyc;
	lsip_row_t rows [14] = '{
		'{0, IDX_BIDIR_DIR, 8'h00, 8'hFF, 0}, '{0, IDX_ONE_DIR, 8'h00, 8'hFF, 0},
		'{0, IDX_TWO_DIR, 8'h00, 8'hFF, 0}, '{0, IDX_THREE_DIR, 8'h00, 8'hFF, 0},
		'{0, IDX_SEG_ENABLE, 8'h00, 8'hFF, 0}, '{0, 9'h00A, 8'h00, 8'h00, 1},
		'{1, IDX_ONE_DIR, 8'h00, 8'h00, 0}, '{0, IDX_ONE_DIR, 8'h00, 8'h00, 0},
		'{1, IDX_THREE_DIR, 8'h3C, 8'h00, 0}, '{0, IDX_THREE_DIR, 8'h00, 8'h3C, 0},
		'{1, IDX_BIDIR_DATA, 8'h15, 8'h00, 0}, '{1, IDX_BIDIR_DIR, 8'hE0, 8'h00, 0},
		'{0, IDX_BIDIR_DIR, 8'h00, 8'hE0, 0}, '{0, IDX_BIDIR_DATA, 8'h00, 8'h00, 0}
	};
	lsip_top u_lsip_top (.clk, .resetn, .ce, .paddr, .psel, .penable,
		.pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .segDrive,
		.comDrive, .comMode, .bidirPinIn, .bidirPinOut, .bidirPinOe, .onePinIn,
		.onePinOut, .onePinOe, .twoPinIn, .twoPinOut, .twoPinOe, .threePinIn,
		.threePinOut, .threePinOe, .segPinEnable);
	lsip_pin_model u_lsip_pin_model (.ext, .bidirPinOut, .bidirPinOe,
		.onePinOut, .onePinOe, .twoPinOut, .twoPinOe, .threePinOut,
		.threePinOe, .bidirPinIn, .onePinIn, .twoPinIn, .threePinIn);
	// Clock of 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask
	task stop_test;
		$display("Counts: fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task apb(input logic w, input logic [IDX_W-1:0] i, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [IDX_W-1:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h00);
		chk("prdata", r, {24'h0, x});
	endtask
	task settle;
		repeat (2) @(posedge clk);
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			fails++;
			stop_test;
		end
	end
	initial begin
		{resetn, psel, penable, pwrite, comMode, paddr, pwdata} = '0;
		{fails, compares, cyc} = '0;
		ce = 1'b1;
		pstrb = 4'hF;
		segDrive = 32'hA5F03C96;
		comDrive = 3'b011;
		ext = 32'hD3695CAA;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		settle;
		for (int k = 0; k < $size(rows); k++) begin
			apb(rows[k].w, rows[k].i, rows[k].d);
			chk("pslverr", e, rows[k].e);
			if (!rows[k].w) chk("prdata", r, {24'h0, rows[k].x});
		end
		chk("bidirOe", bidirPinOe, 8'hFF);
		chk("bidirOut", bidirPinOut, {segDrive[31:29], segDrive[4:0]});
		chk("oneOut", onePinOut, {segDrive[27], segDrive[11:5]});
		chk("twoOut", twoPinOut, segDrive[19:12]);
		chk("threeOut", threePinOut, {segDrive[28], segDrive[26:20]});
		chk("inOe", {onePinOe, twoPinOe, threePinOe}, 24'hFFFFFF);
		comMode <= 1'b1;
		settle;
		chk("comOut", bidirPinOut[7:5], 3'b110);
		// Clock enable low freezes the pin registers
		ce <= 1'b0;
		segDrive <= 32'h5A0FC369;
		settle;
		chk("frozenOut", bidirPinOut[4:0], 5'h16);
		ce <= 1'b1;
		settle;
		chk("bidirOut", bidirPinOut[4:0], 5'h09);
		apb(1'b1, IDX_SEG_ENABLE, 8'h7E);
		settle;
		chk("bidirOe", bidirPinOe, 8'h1F);
		chk("bidirOut", bidirPinOut[4:0], 5'h15);
		rd(IDX_BIDIR_DATA, 8'hB5);
		apb(1'b1, IDX_BIDIR_DIR, 8'h00);
		settle;
		chk("bidirOe", bidirPinOe, 8'h1F);
		apb(1'b1, IDX_BIDIR_DIR, 8'h0A);
		settle;
		chk("bidirOe", bidirPinOe, 8'h15);
		rd(IDX_BIDIR_DATA, 8'hBF);
		apb(1'b1, IDX_SEG_ENABLE, 8'h38);
		settle;
		chk("oneOe", onePinOe, 8'h00);
		chk("threeOe", threePinOe, 8'h7F);
		rd(IDX_ONE_DATA, 8'h5C);
		rd(IDX_THREE_DATA, 8'h80);
		apb(1'b1, IDX_SEG_ENABLE, 8'h20);
		settle;
		chk("twoOe", twoPinOe, 8'h00);
		rd(IDX_TWO_DATA, 8'h69);
		apb(1'b1, IDX_SEG_ENABLE, 8'h00);
		settle;
		rd(IDX_THREE_DATA, 8'hD3);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		settle;
		chk("bidirOe", bidirPinOe, 8'hFF);
		rd(IDX_SEG_ENABLE, 8'hFF);
		rd(IDX_BIDIR_DIR, 8'hFF);
		apb(1'b1, IDX_SEG_ENABLE, 8'hFE);
		apb(1'b1, IDX_BIDIR_DIR, 8'h00);
		settle;
		chk("bidirOut", bidirPinOut[4:0], 5'h00);
		// A write without its low byte strobe is ignored
		pstrb <= 4'hE;
		apb(1'b1, IDX_BIDIR_DIR, 8'hFF);
		pstrb <= 4'hF;
		settle;
		chk("bidirOe", bidirPinOe[4:0], 5'h1F);
		chk("segEn", segPinEnable, 8'hFE);
		rd(IDX_BIDIR_DIR, 8'h00);
		stop_test;
	end
endmodule
`default_nettype wire
